/* design/fnp_host.sv */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module fnp_host #(
   parameter int OP_CYC = fnp_pkg::NVM_OP_CYC
) (
   input wire logic CLK,
   input wire logic RESETN,
   fnp_link_if.host LINK,
   input wire logic [3:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [3:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_HOLD} fnp_host_state_t;

   fnp_host_state_t st_ff;
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_bus_ff;
   logic [3:0] awaddr_ff;
   logic [31:0] wdata_bus_ff;
   logic [3:0] wstrb_ff;
   logic [7:0] reg_ff;
   logic rd_ff;
   logic [15:0] wdata_ff;
   logic [15:0] rdata_ff;
   logic nack_ff;
   logic [1:0] sda_sy_ff;
   logic [6:0] qcnt_ff;
   logic [1:0] q_ff;
   logic [3:0] b_ff;
   logic [2:0] idx_ff;
   logic [7:0] rx_ff;
   logic ackbit_ff;
   logic scl_ff, oe_ff;
   logic [20:0] hold_ff;

   // ----------------------------------------------------------------
   // AXI4-Lite decode
   // ----------------------------------------------------------------
   wire aw_hs = S_AXI_AWVALID & awready_ff;
   wire w_hs = S_AXI_WVALID & wready_ff;
   wire do_wr = ~awready_ff & ~wready_ff & ~bvalid_ff;
   wire wr_cmd = do_wr && awaddr_ff == fnp_pkg::HOST_CMD && wstrb_ff[0];
   wire wr_wd = do_wr && awaddr_ff == fnp_pkg::HOST_WDATA;
   wire wr_ok = awaddr_ff == fnp_pkg::HOST_CMD || awaddr_ff == fnp_pkg::HOST_WDATA;
   wire go = wr_cmd && wdata_bus_ff[fnp_pkg::CMD_GO] && st_ff == H_IDLE;
   wire ar_hs = S_AXI_ARVALID & arready_ff;
   wire busy = st_ff != H_IDLE;
   wire [31:0] stat_word = {29'h0, st_ff == H_HOLD, nack_ff, busy};
   wire [31:0] cmd_word = {16'h0, reg_ff, 6'h00, rd_ff, 1'b0};
   wire ar_cmd = S_AXI_ARADDR == fnp_pkg::HOST_CMD;
   wire ar_wd = S_AXI_ARADDR == fnp_pkg::HOST_WDATA;
   wire ar_rd = S_AXI_ARADDR == fnp_pkg::HOST_RDATA;
   wire ar_st = S_AXI_ARADDR == fnp_pkg::HOST_STAT;
   wire [31:0] rd_mux = ar_cmd ? cmd_word : ar_wd ? {16'h0, wdata_ff} :
      ar_rd ? {16'h0, rdata_ff} : ar_st ? stat_word : 32'h0;

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         bvalid_ff <= 1'b0;
         bresp_ff <= fnp_pkg::AXI_OKAY;
         awaddr_ff <= 4'h0;
         wdata_bus_ff <= 32'h0;
         wstrb_ff <= 4'h0;
      end
      else
      begin
         if (aw_hs)
         begin
            awready_ff <= 1'b0;
            awaddr_ff <= S_AXI_AWADDR;
         end
         if (w_hs)
         begin
            wready_ff <= 1'b0;
            wdata_bus_ff <= S_AXI_WDATA;
            wstrb_ff <= S_AXI_WSTRB;
         end
         if (do_wr)
         begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? fnp_pkg::AXI_OKAY : fnp_pkg::AXI_SLVERR;
         end
         else if (bvalid_ff && S_AXI_BREADY)
         begin
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_bus_ff <= 32'h0;
         rresp_ff <= fnp_pkg::AXI_OKAY;
      end
      else if (ar_hs)
      begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_bus_ff <= rd_mux;
         rresp_ff <= (ar_cmd | ar_wd | ar_rd | ar_st) ? fnp_pkg::AXI_OKAY : fnp_pkg::AXI_SLVERR;
      end
      else if (rvalid_ff && S_AXI_RREADY)
      begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Serial master
   // ----------------------------------------------------------------
   wire tick = qcnt_ff == 7'(fnp_pkg::QTR_CYC - 1);
   wire sda = sda_sy_ff[1];
   wire rx_byte = rd_ff && idx_ff >= 3'h3;
   wire [7:0] tx_byte = (idx_ff == 3'h0) ? {fnp_pkg::DEV_ADDR, 1'b0} :
      (idx_ff == 3'h1) ? reg_ff :
      (idx_ff == 3'h2) ? (rd_ff ? {fnp_pkg::DEV_ADDR, 1'b1} : wdata_ff[15:8]) :
      (idx_ff == 3'h3) ? wdata_ff[7:0] : 8'hFF;
   wire data_bit = rx_byte ? 1'b1 : tx_byte[3'(4'h7 - b_ff)];
   wire ack_slot = rx_byte ? (idx_ff == 3'h4) : 1'b1;
   wire bit_val = (b_ff == 4'h8) ? ack_slot : data_bit;
   wire last = rd_ff ? (idx_ff == 3'h1 || idx_ff == 3'h4) : idx_ff == 3'h3;
   wire is_prog = reg_ff == fnp_pkg::REG_CTRL && wdata_ff[fnp_pkg::CTRL_EN] &&
      (wdata_ff[fnp_pkg::CTRL_ER] || wdata_ff[fnp_pkg::CTRL_WR]);

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         sda_sy_ff <= 2'h3;
         reg_ff <= 8'h00;
         rd_ff <= 1'b0;
         wdata_ff <= 16'h0000;
      end
      else
      begin
         sda_sy_ff <= {sda_sy_ff[0], LINK.tach_pin};
         if (wr_cmd && st_ff == H_IDLE)
         begin
            reg_ff <= wdata_bus_ff[fnp_pkg::CMD_REG_LSB +: 8];
            rd_ff <= wdata_bus_ff[fnp_pkg::CMD_READ];
         end
         if (wr_wd && st_ff == H_IDLE)
         begin
            if (wstrb_ff[0])
               wdata_ff[7:0] <= wdata_bus_ff[7:0];
            if (wstrb_ff[1])
               wdata_ff[15:8] <= wdata_bus_ff[15:8];
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st_ff <= H_IDLE;
         qcnt_ff <= 7'h00;
         q_ff <= 2'h0;
         b_ff <= 4'h0;
         idx_ff <= 3'h0;
         rx_ff <= 8'h00;
         ackbit_ff <= 1'b0;
         rdata_ff <= 16'h0000;
         nack_ff <= 1'b0;
         scl_ff <= 1'b1;
         oe_ff <= 1'b0;
         hold_ff <= 21'h000000;
      end
      else if (go)
      begin
         st_ff <= H_START;
         qcnt_ff <= 7'h00;
         q_ff <= 2'h0;
         idx_ff <= 3'h0;
         nack_ff <= 1'b0;
      end
      else if (st_ff == H_HOLD)
      begin
         hold_ff <= hold_ff + 21'h000001;
         if (hold_ff == 21'(OP_CYC - 1))
            st_ff <= H_IDLE;
      end
      else if (st_ff != H_IDLE)
      begin
         qcnt_ff <= tick ? 7'h00 : qcnt_ff + 7'h01;
         if (tick)
         begin
            q_ff <= q_ff + 2'h1;
            case (st_ff)
               H_START:
               begin
                  if (q_ff == 2'h0)
                  begin
                     oe_ff <= 1'b0;
                     scl_ff <= 1'b1;
                  end
                  if (q_ff == 2'h1)
                     oe_ff <= 1'b1;
                  if (q_ff == 2'h3)
                  begin
                     scl_ff <= 1'b0;
                     b_ff <= 4'h0;
                     st_ff <= H_BIT;
                  end
               end
               H_BIT:
               begin
                  if (q_ff == 2'h0)
                     oe_ff <= ~bit_val;
                  if (q_ff == 2'h1)
                     scl_ff <= 1'b1;
                  if (q_ff == 2'h2)
                  begin
                     if (b_ff != 4'h8)
                        rx_ff <= {rx_ff[6:0], sda};
                     else
                        ackbit_ff <= sda;
                  end
                  if (q_ff == 2'h3)
                  begin
                     scl_ff <= 1'b0;
                     b_ff <= (b_ff == 4'h8) ? 4'h0 : b_ff + 4'h1;
                     if (b_ff == 4'h8)
                     begin
                        if (rx_byte && idx_ff == 3'h3)
                           rdata_ff[15:8] <= rx_ff;
                        if (rx_byte && idx_ff == 3'h4)
                           rdata_ff[7:0] <= rx_ff;
                        if (!rx_byte && ackbit_ff)
                        begin
                           nack_ff <= 1'b1;
                           st_ff <= H_STOP;
                        end
                        else if (last)
                           st_ff <= H_STOP;
                        else
                           idx_ff <= idx_ff + 3'h1;
                     end
                  end
               end
               H_STOP:
               begin
                  if (q_ff == 2'h0)
                     oe_ff <= 1'b1;
                  if (q_ff == 2'h1)
                     scl_ff <= 1'b1;
                  if (q_ff == 2'h2)
                     oe_ff <= 1'b0;
                  if (q_ff == 2'h3)
                  begin
                     hold_ff <= 21'h000000;
                     if (rd_ff && idx_ff == 3'h1 && !nack_ff)
                     begin
                        idx_ff <= 3'h2;
                        st_ff <= H_START;
                     end
                     else if (!rd_ff && !nack_ff && is_prog)
                        st_ff <= H_HOLD;
                     else
                        st_ff <= H_IDLE;
                  end
               end
               default:
               begin
                  st_ff <= H_IDLE;
               end
            endcase
         end
      end
   end

   assign LINK.speed_pin = scl_ff;
   assign LINK.host_tach_o = 1'b0;
   assign LINK.host_tach_oe = oe_ff;
   assign S_AXI_AWREADY = awready_ff;
   assign S_AXI_WREADY = wready_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;
   assign S_AXI_ARREADY = arready_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_bus_ff;
   assign S_AXI_RRESP = rresp_ff;
endmodule

/* design/fnp_pkg.sv */
package fnp_pkg;
   // ----------------------------------------------------------------
   // Link and device register map
   // ----------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR = 7'h55;
   localparam logic [7:0] REG_CTRL = 8'hA1;
   localparam logic [7:0] REG_WSEL = 8'hA2;
   localparam logic [7:0] REG_WVAL = 8'hA3;
   localparam logic [7:0] REG_RVAL = 8'hA4;
   localparam int CTRL_EN = 0;
   localparam int CTRL_ER = 1;
   localparam int CTRL_WR = 2;
   localparam int CTRL_RD = 3;
   localparam int CTRL_W = 4;
   localparam int NVM_WORDS = 32;
   localparam int NVM_WIDTH = 16;
   localparam int NVM_AW = 5;
   localparam logic [15:0] ERASED_WORD = 16'h0000;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int NVM_OP_MS = 12;
   localparam int NVM_OP_CYC = NVM_OP_MS * 1000 * CLK_MHZ;
   localparam int QTR_CYC = 63;
   // ----------------------------------------------------------------
   // Controller registers on AXI4-Lite
   // ----------------------------------------------------------------
   localparam logic [3:0] HOST_CMD = 4'h0;
   localparam logic [3:0] HOST_WDATA = 4'h4;
   localparam logic [3:0] HOST_RDATA = 4'h8;
   localparam logic [3:0] HOST_STAT = 4'hC;
   localparam int CMD_GO = 0;
   localparam int CMD_READ = 1;
   localparam int CMD_REG_LSB = 8;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

/* design/fnp_link_if.sv */
`timescale 1ns/1ps
interface fnp_link_if;
   logic speed_pin;
   logic tach_pin;
   logic host_tach_o;
   logic host_tach_oe;
   logic dev_tach_o;
   logic dev_tach_oe;
   // Open-drain data line with pull-up
   assign tach_pin = ~((host_tach_oe & ~host_tach_o) | (dev_tach_oe & ~dev_tach_o));
   modport dev (input speed_pin, input tach_pin, output dev_tach_o, output dev_tach_oe);
   modport host (output speed_pin, input tach_pin, output host_tach_o, output host_tach_oe);
endinterface

/* design/fnp_dev.sv */
// Functional notes
// - Store of 32 words, 16 bits each
// - Control bits: voltage, erase, write, read
// - Host keeps control bits 15:4 zero
// - Word index in bits 4:0, rest zero
// - Write value register holds all 16 bits
// - Read-back register shows addressed word contents
// - Only read, erase and write operations
// - Host erases a word before writing it
// - Erase or write lasts 12 ms
// - One word per operation, no blocks
// - Erase: index, zero data, control 3
// - Program: index, value, control 5, wait
// - Target answers to address 0x55
// - Write: address, register, two bytes MSB first
// - Read: set pointer, stop, then read two bytes
// - Speed pin clocks, tach pin carries data
`timescale 1ns/1ps
module fnp_dev #(
   parameter int OP_CYC = fnp_pkg::NVM_OP_CYC
) (
   input wire logic CLK,
   input wire logic RESETN,
   fnp_link_if.dev LINK,
   output logic NVM_BUSY
);
   typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK} fnp_dev_state_t;

   fnp_dev_state_t state_ff;
   logic [2:0] scl_sy_ff;
   logic [2:0] sda_sy_ff;
   logic [7:0] shift_ff;
   logic [3:0] bcnt_ff;
   logic [2:0] idx_ff;
   logic rw_ff;
   logic ack_pend_ff;
   logic tx_lo_ff;
   logic oe_ff;
   logic [7:0] ptr_ff;
   logic [7:0] hi_ff;
   logic [fnp_pkg::CTRL_W-1:0] ctrl_ff;
   logic [fnp_pkg::NVM_AW-1:0] sel_ff;
   logic [15:0] wval_ff;
   logic [15:0] fetched_ff;
   logic busy_ff;
   logic [20:0] timer_ff;
   logic [fnp_pkg::NVM_AW-1:0] op_addr_ff;
   logic [15:0] op_data_ff;
   logic op_is_wr_ff;
   logic [15:0] mem [fnp_pkg::NVM_WORDS];

   // ----------------------------------------------------------------
   // Pin sampling and bus conditions
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         scl_sy_ff <= 3'h7;
         sda_sy_ff <= 3'h7;
      end
      else
      begin
         scl_sy_ff <= {scl_sy_ff[1:0], LINK.speed_pin};
         sda_sy_ff <= {sda_sy_ff[1:0], LINK.tach_pin};
      end
   end

   wire scl = scl_sy_ff[1];
   wire scl_d = scl_sy_ff[2];
   wire sda = sda_sy_ff[1];
   wire sda_d = sda_sy_ff[2];
   wire scl_rise = scl & ~scl_d;
   wire scl_fall = ~scl & scl_d;
   wire i2c_start = scl & scl_d & sda_d & ~sda;
   wire i2c_stop = scl & scl_d & ~sda_d & sda;
   wire [7:0] byte_in = {shift_ff[6:0], sda};
   wire byte_done = (state_ff == D_RX) && scl_rise && (bcnt_ff == 4'h7);
   wire addr_match = (byte_in[7:1] == fnp_pkg::DEV_ADDR);

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   wire reg_wr = byte_done && (idx_ff == 3'h3) && !rw_ff;
   wire [15:0] wr_data = {hi_ff, byte_in};
   wire ctrl_wr = reg_wr && (ptr_ff == fnp_pkg::REG_CTRL);
   wire en_bit = wr_data[fnp_pkg::CTRL_EN];
   wire op_erase = ctrl_wr && !busy_ff && en_bit && wr_data[fnp_pkg::CTRL_ER];
   wire op_write = ctrl_wr && !busy_ff && en_bit && wr_data[fnp_pkg::CTRL_WR];
   wire op_read = ctrl_wr && !busy_ff && !en_bit && wr_data[fnp_pkg::CTRL_RD];
   wire op_go = op_erase | op_write;
   wire op_done = busy_ff && (timer_ff == 21'(OP_CYC - 1));
   wire [15:0] rd_word =
      (ptr_ff == fnp_pkg::REG_CTRL) ? {12'h000, ctrl_ff} :
      (ptr_ff == fnp_pkg::REG_WSEL) ? {11'h000, sel_ff} :
      (ptr_ff == fnp_pkg::REG_WVAL) ? wval_ff :
      (ptr_ff == fnp_pkg::REG_RVAL) ? fetched_ff : 16'h0000;
   wire [7:0] tx_next = tx_lo_ff ? rd_word[7:0] : rd_word[15:8];

   // ----------------------------------------------------------------
   // Serial target
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state_ff <= D_IDLE;
         shift_ff <= 8'h00;
         bcnt_ff <= 4'h0;
         idx_ff <= 3'h0;
         rw_ff <= 1'b0;
         ack_pend_ff <= 1'b0;
         tx_lo_ff <= 1'b0;
         oe_ff <= 1'b0;
         ptr_ff <= 8'h00;
         hi_ff <= 8'h00;
      end
      else if (i2c_start)
      begin
         state_ff <= D_RX;
         bcnt_ff <= 4'h0;
         idx_ff <= 3'h0;
         rw_ff <= 1'b0;
         ack_pend_ff <= 1'b0;
         oe_ff <= 1'b0;
      end
      else if (i2c_stop)
      begin
         state_ff <= D_IDLE;
         oe_ff <= 1'b0;
      end
      else
      begin
         case (state_ff)
            D_IDLE:
            begin
               oe_ff <= 1'b0;
            end
            D_RX:
            begin
               if (scl_rise)
               begin
                  shift_ff <= byte_in;
                  bcnt_ff <= bcnt_ff + 4'h1;
               end
               if (byte_done)
               begin
                  if (idx_ff == 3'h0 && !addr_match)
                     state_ff <= D_IDLE;
                  else
                     ack_pend_ff <= 1'b1;
                  if (idx_ff == 3'h0)
                     rw_ff <= byte_in[0];
                  if (idx_ff == 3'h1)
                     ptr_ff <= byte_in;
                  if (idx_ff == 3'h2)
                     hi_ff <= byte_in;
                  if (idx_ff != 3'h4)
                     idx_ff <= idx_ff + 3'h1;
               end
               else if (scl_fall && ack_pend_ff)
               begin
                  state_ff <= D_ACK;
                  oe_ff <= 1'b1;
                  ack_pend_ff <= 1'b0;
               end
            end
            D_ACK:
            begin
               if (scl_fall)
               begin
                  bcnt_ff <= 4'h0;
                  if (rw_ff)
                  begin
                     state_ff <= D_TX;
                     shift_ff <= rd_word[15:8];
                     oe_ff <= ~rd_word[15];
                     tx_lo_ff <= 1'b1;
                  end
                  else
                  begin
                     state_ff <= D_RX;
                     oe_ff <= 1'b0;
                  end
               end
            end
            D_TX:
            begin
               if (scl_rise)
                  bcnt_ff <= bcnt_ff + 4'h1;
               if (scl_fall)
               begin
                  if (bcnt_ff == 4'h8)
                  begin
                     oe_ff <= 1'b0;
                     state_ff <= D_TXACK;
                  end
                  else
                  begin
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     oe_ff <= ~shift_ff[6];
                  end
               end
            end
            D_TXACK:
            begin
               if (scl_rise && sda)
                  state_ff <= D_IDLE;
               else if (scl_fall)
               begin
                  state_ff <= D_TX;
                  bcnt_ff <= 4'h0;
                  shift_ff <= tx_next;
                  oe_ff <= ~tx_next[7];
                  tx_lo_ff <= ~tx_lo_ff;
               end
            end
            default:
            begin
               state_ff <= D_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Memory registers and operation timer
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         ctrl_ff <= 4'h0;
         sel_ff <= 5'h00;
         wval_ff <= 16'h0000;
      end
      else if (reg_wr)
      begin
         if (ptr_ff == fnp_pkg::REG_CTRL)
            ctrl_ff <= wr_data[3:0];
         if (ptr_ff == fnp_pkg::REG_WSEL)
            sel_ff <= wr_data[4:0];
         if (ptr_ff == fnp_pkg::REG_WVAL)
            wval_ff <= wr_data;
      end
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         fetched_ff <= 16'h0000;
      else if (op_read)
         fetched_ff <= mem[sel_ff];
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         busy_ff <= 1'b0;
         timer_ff <= 21'h000000;
         op_addr_ff <= 5'h00;
         op_data_ff <= 16'h0000;
         op_is_wr_ff <= 1'b0;
      end
      else if (op_go)
      begin
         busy_ff <= 1'b1;
         timer_ff <= 21'h000000;
         op_addr_ff <= sel_ff;
         op_data_ff <= wval_ff;
         op_is_wr_ff <= ~op_erase;
      end
      else if (op_done)
         busy_ff <= 1'b0;
      else if (busy_ff)
         timer_ff <= timer_ff + 21'h000001;
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         for (int i = 0; i < fnp_pkg::NVM_WORDS; i++)
            mem[i] <= fnp_pkg::ERASED_WORD;
      end
      else if (op_done)
         mem[op_addr_ff] <= op_is_wr_ff ? op_data_ff : fnp_pkg::ERASED_WORD;
   end

   assign NVM_BUSY = busy_ff;
   assign LINK.dev_tach_o = 1'b0;
   assign LINK.dev_tach_oe = oe_ff;
endmodule

/* testbench/fnp_link_checker.sv */
`timescale 1ns/1ps
module fnp_link_checker #(
   parameter int OP_CYC = fnp_pkg::NVM_OP_CYC
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic speed_pin,
   input wire logic tach_pin,
   input wire logic host_tach_o,
   input wire logic host_tach_oe,
   input wire logic dev_tach_o,
   input wire logic dev_tach_oe,
   input wire logic NVM_BUSY
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   logic [31:0] busy_cnt_ff;
   logic [31:0] nxt_busy_cnt;
   // Length of the current busy stretch
   assign nxt_busy_cnt = NVM_BUSY ? busy_cnt_ff + 32'h1 : 32'h0;
   always_ff @(posedge CLK or negedge RESETN)
      if (!RESETN)
         busy_cnt_ff <= 32'h0;
      else
         busy_cnt_ff <= nxt_busy_cnt;
   sequence s_scl_hi;
      speed_pin [*8];
   endsequence
   sequence s_scl_lo;
      !speed_pin [*8];
   endsequence
   a_host_od: assert property (!host_tach_o) else $error("host drives data high");
   a_dev_od: assert property (!dev_tach_o) else $error("device drives data high");
   a_scl_high: assert property ($rose(speed_pin) |-> s_scl_hi)
      else $error("clock high short");
   a_scl_low: assert property ($fell(speed_pin) |-> s_scl_lo) else $error("clock low short");
   a_dev_data_stable: assert property (speed_pin && $past(speed_pin) |->
      $stable(dev_tach_oe)) else $error("device data moved with clock high");
   a_start_by_host: assert property ($fell(tach_pin) && speed_pin |-> host_tach_oe)
      else $error("start not made by host");
   a_busy_span: assert property ($fell(NVM_BUSY) |-> busy_cnt_ff == OP_CYC)
      else $error("operation length wrong");
   a_busy_bound: assert property (busy_cnt_ff <= OP_CYC) else $error("busy overrun");
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   localparam int OP = 200;
   logic CLK;
   logic RESETN;
   logic busy;
   logic aw_v, aw_rdy, w_v, w_rdy, b_v, b_rdy, ar_v, ar_rdy, r_v, r_rdy;
   logic [3:0] aw_addr, ar_addr, w_strb;
   logic [31:0] w_data, r_data, d;
   logic [1:0] b_resp, r_resp, rs;
   logic [15:0] seed;
   logic [4:0] wi;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   fnp_link_if link();
   fnp_dev #(.OP_CYC(OP)) u_fnp_dev(.CLK(CLK), .RESETN(RESETN), .LINK(link.dev), .NVM_BUSY(busy));
   fnp_host #(.OP_CYC(OP)) u_fnp_host(.CLK(CLK), .RESETN(RESETN), .LINK(link.host),
      .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy),
      .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy),
      .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_rdy),
      .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy),
      .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_rdy));
   fnp_link_checker #(.OP_CYC(OP)) u_fnp_link_checker(.CLK(CLK), .RESETN(RESETN),
      .speed_pin(link.speed_pin), .tach_pin(link.tach_pin), .host_tach_o(link.host_tach_o),
      .host_tach_oe(link.host_tach_oe), .dev_tach_o(link.dev_tach_o),
      .dev_tach_oe(link.dev_tach_oe), .NVM_BUSY(busy));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] exp_word(input logic erased, input logic [15:0] v);
      return erased ? {16'h0, fnp_pkg::ERASED_WORD} : {16'h0, v};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
      bit ga;
      bit gw;
      ga = 0;
      gw = 0;
      @(posedge CLK);
      aw_addr <= a;
      w_data <= v;
      w_strb <= s;
      {aw_v, w_v, b_rdy} <= 3'h7;
      while (!(ga && gw))
      begin
         @(posedge CLK);
         ga = ga | aw_rdy;
         gw = gw | w_rdy;
         aw_v <= ~ga;
         w_v <= ~gw;
      end
      do @(posedge CLK); while (b_v !== 1'b1);
      rs = b_resp;
      b_rdy <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] a);
      @(posedge CLK);
      ar_addr <= a;
      {ar_v, r_rdy} <= 2'h3;
      do @(posedge CLK); while (ar_rdy !== 1'b1);
      ar_v <= 1'b0;
      do @(posedge CLK); while (r_v !== 1'b1);
      d = r_data;
      rs = r_resp;
      r_rdy <= 1'b0;
   endtask
   // One link transfer, then poll status until idle
   task automatic link_op(input logic [7:0] r, input logic rd);
      axi_wr(4'h0, {16'h0, r, 6'h0, rd, 1'b1}, 4'hF);
      do axi_rd(4'hC); while (d[0] !== 1'b0);
      chk(d, 32'h0);
   endtask
   task automatic dev_wr(input logic [7:0] r, input logic [15:0] v);
      axi_wr(4'h4, {16'h0, v}, 4'hF);
      link_op(r, 1'b0);
   endtask
   initial
   begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   always @(posedge CLK)
   begin
      cyc++;
      if (cyc == 100000)
      begin
         num_errors++;
         $display("[ERR] %0t timeout", $time);
         close_out();
      end
   end
   initial
   begin
      {aw_v, w_v, b_rdy, ar_v, r_rdy, aw_addr, ar_addr, w_data, w_strb} = '0;
      RESETN = 1'b0;
      seed = 16'h003A;
      repeat (8) @(posedge CLK);
      RESETN <= 1'b1;
      axi_wr(4'h2, 32'h1, 4'hF);
      chk({30'h0, rs}, {30'h0, fnp_pkg::AXI_SLVERR});
      axi_rd(4'h6);
      chk({30'h0, rs}, {30'h0, fnp_pkg::AXI_SLVERR});
      chk(d, 32'h0);
      // Start without byte lane 0 must not launch a transfer
      axi_wr(4'h0, 32'h0000A101, 4'h0);
      chk({30'h0, rs}, {30'h0, fnp_pkg::AXI_OKAY});
      axi_rd(4'hC);
      chk(d, 32'h0);
      $display("test map done");
      seed = lfsr(seed);
      wi = seed[4:0];
      dev_wr(fnp_pkg::REG_WSEL, {11'h0, wi});
      seed = lfsr(seed);
      dev_wr(fnp_pkg::REG_WVAL, seed);
      // Word is erased after reset, so it may be programmed directly
      dev_wr(fnp_pkg::REG_CTRL, 16'h0005);
      dev_wr(fnp_pkg::REG_CTRL, 16'h0008);
      link_op(fnp_pkg::REG_RVAL, 1'b1);
      axi_rd(4'h8);
      chk(d, exp_word(1'b0, seed));
      link_op(fnp_pkg::REG_WSEL, 1'b1);
      axi_rd(4'h8);
      chk(d, {27'h0, wi});
      $display("test program done");
      dev_wr(fnp_pkg::REG_CTRL, 16'h0003);
      dev_wr(fnp_pkg::REG_CTRL, 16'h0008);
      link_op(fnp_pkg::REG_RVAL, 1'b1);
      axi_rd(4'h8);
      chk(d, exp_word(1'b1, seed));
      $display("test erase done");
      close_out();
   end
endmodule
